// ---- hdl/islp_log_pages.v ----
// Overview of operation
// - OUI in header dword bits 23:0
// - Empty area one reports last page zero
// - Area one spans page one to last
// - Area two last page not below one
// - Area three last page not below two
// - Current header mirrors saved flag, count
// - Header carries vendor reason code
// - Current pages carry vendor state bytes
// - Saved log survives rst, only nvClr clears it
// - Device alone triggers saved capture
// - Saved header byte zero is 25h
// - Capture stored sets saved-available flag
// - Reading saved data clears available flag
// - Capture start increments generation count
// - Flag at 382, count at 383
// - Eight 16-byte descriptors, then reserved
// - Descriptor field layout, reserved tail
// - Current header byte zero is 24h
// - Snapshot frozen until next capture read
`include "islp_map.vh"

module islp_log_pages #(
  parameter PGW = 3
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        nvClr,
  input  wire        ce,
  input  wire [7:0]  regAddr,
  input  wire [31:0] regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [31:0] regRdData_r,
  input  wire        ucodeAct,
  input  wire        cmdValid,
  input  wire [7:0]  cmdLog,
  input  wire [15:0] cmdPage,
  input  wire        cmdFeat0,
  output reg         busy_r,
  output reg         cmdErr_r,
  output reg         dataValid_r,
  output reg  [7:0]  dataByte_r,
  output reg         dataLast_r
);
  localparam AW = PGW + 11;
  localparam [15:0] MAXPG = (16'h0001 << PGW);
  localparam SRC_HDR = 2'h0;
  localparam SRC_MEM = 2'h1;
  localparam SRC_SEC = 2'h2;
  // Firmware control registers
  reg  [1:0]    cfg_r;
  reg  [23:0]   oui_r;
  reg  [15:0]   area1_r, area2_r, area3_r;
  reg  [31:0]   reason_r;
  reg  [AW+1:0] memAddr_r;
  // Frozen snapshot of the current log
  reg           snapValid_r;
  reg           liveBank_r;
  reg           frozenBank_r;
  reg  [23:0]   snapOui_r;
  reg  [15:0]   snapA1_r, snapA2_r, snapA3_r;
  reg  [31:0]   snapRsn_r;
  // Persistent saved log header
  reg           savedAvail_r;
  reg  [7:0]    savedGen_r;
  reg  [23:0]   savedOui_r;
  reg  [15:0]   savedA1_r, savedA2_r, savedA3_r;
  reg  [31:0]   savedRsn_r;
  // Transfer state
  reg  [8:0]    idx_r;
  reg  [1:0]    src_r;
  reg  [7:0]    log_r;
  reg  [1:0]    rgn_r;
  reg  [PGW-1:0] pg_r;
  reg           p1Valid_r;
  reg  [8:0]    p1Idx_r;
  reg           p1Last_r;
  reg           hdrAvail_r;
  wire          savedSup = cfg_r[`ISLP_CFG_SAVEDSUP];
  wire          wrCmd    = ce & regWr & (regAddr == `ISLP_REG_CMD);
  wire          capStart = wrCmd & regWrData[`ISLP_CMD_CAPSTART];
  wire          capCommit = wrCmd & regWrData[`ISLP_CMD_CAPCOMMIT];
  wire          memWr    = ce & regWr & (regAddr == `ISLP_REG_MEMDATA);
  wire [7:0]    memRd;
  reg  [AW-1:0] memWrAddr;
  wire [AW-1:0] memRdAddr = {rgn_r, pg_r, idx_r};
  wire [15:0] a1Eff = cfg_r[`ISLP_CFG_AREA1DATA] ? area1_r : 16'h0000;
  wire [15:0] a2Eff = (area2_r < a1Eff) ? a1Eff : area2_r;
  wire [15:0] a3Eff = (area3_r < a2Eff) ? a2Eff : area3_r;
  // Command classification
  wire isCur  = (cmdLog == `ISLP_LOG_CURRENT);
  wire isSav  = (cmdLog == `ISLP_LOG_SAVED) & savedSup;
  wire isSec  = (cmdLog == `ISLP_LOG_SECTOR);
  wire takeSnap = isCur & (cmdFeat0 | ~snapValid_r);
  wire [15:0] curLast = takeSnap ? a3Eff : snapA3_r;
  wire [15:0] limit   = isCur ? curLast : savedA3_r;
  wire pageBad = (cmdPage > limit) | (cmdPage > MAXPG);
  wire cmdBad  = ~(isCur | isSav | isSec) | (isSec & (cmdPage != 16'h0000))
                 | ((isCur | isSav) & pageBad);
  wire accept  = ce & cmdValid & ~busy_r;
  wire [15:0] pgIdx = cmdPage - 16'h0001;
  // Firmware region to physical memory region
  always @* begin
    memWrAddr = memAddr_r[AW-1:0];
    case (memAddr_r[AW+1:AW])
      `ISLP_RGN_LIVE:   memWrAddr[AW-1:AW-2] = {1'b0, liveBank_r};
      `ISLP_RGN_SAVED:  memWrAddr[AW-1:AW-2] = 2'h2;
      `ISLP_RGN_SECTOR: memWrAddr[AW-1:AW-2] = 2'h3;
      default:          memWrAddr[AW-1:AW-2] = 2'h3;
    endcase
  end
  // Header page byte builder
  function [7:0] hdrByte;
    input [8:0]  i;
    input [7:0]  id;
    input [23:0] oui;
    input [15:0] a1, a2, a3;
    input [7:0]  av, gen;
    input [31:0] rsn;
    begin
      case (i)
        `ISLP_HDR_ID:   hdrByte = id;
        `ISLP_HDR_OUI0: hdrByte = oui[7:0];
        `ISLP_HDR_OUI1: hdrByte = oui[15:8];
        `ISLP_HDR_OUI2: hdrByte = oui[23:16];
        `ISLP_HDR_A1LO: hdrByte = a1[7:0];
        `ISLP_HDR_A1HI: hdrByte = a1[15:8];
        `ISLP_HDR_A2LO: hdrByte = a2[7:0];
        `ISLP_HDR_A2HI: hdrByte = a2[15:8];
        `ISLP_HDR_A3LO: hdrByte = a3[7:0];
        `ISLP_HDR_A3HI: hdrByte = a3[15:8];
        `ISLP_HDR_AVAIL: hdrByte = av;
        `ISLP_HDR_GEN:  hdrByte = gen;
        `ISLP_HDR_RSN0: hdrByte = rsn[7:0];
        `ISLP_HDR_RSN1: hdrByte = rsn[15:8];
        `ISLP_HDR_RSN2: hdrByte = rsn[23:16];
        `ISLP_HDR_RSN3: hdrByte = rsn[31:24];
        default:        hdrByte = 8'h00;
      endcase
    end
  endfunction
  // Output byte for the stage behind the memory
  reg [7:0] outByte;
  always @* begin
    outByte = 8'h00;
    case (src_r)
      SRC_HDR: begin
        if (log_r == `ISLP_LOG_CURRENT) begin
          outByte = hdrByte(p1Idx_r, `ISLP_LOG_CURRENT, snapOui_r,
                            snapA1_r, snapA2_r, snapA3_r,
                            {7'h00, savedSup & savedAvail_r},
                            savedSup ? savedGen_r : 8'h00, snapRsn_r);
        end else begin
          outByte = hdrByte(p1Idx_r, `ISLP_LOG_SAVED, savedOui_r,
                            savedA1_r, savedA2_r, savedA3_r,
                            {7'h00, hdrAvail_r}, savedGen_r, savedRsn_r);
        end
      end
      SRC_MEM: outByte = memRd;
      SRC_SEC: begin
        if (p1Idx_r >= `ISLP_SEC_TABLE_END) begin
          outByte = 8'h00;
        end else if (p1Idx_r[3:0] >= `ISLP_SEC_RSVD_OFS) begin
          outByte = 8'h00;
        end else if (p1Idx_r[3:0] == 4'h0) begin
          outByte = memRd & `ISLP_SEC_VALID_MSK;
        end else begin
          outByte = memRd;
        end
      end
      default: outByte = 8'h00;
    endcase
  end

  // Firmware register writes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_r     <= `ISLP_CFG_RST;
      oui_r     <= `ISLP_OUI_RST;
      area1_r   <= `ISLP_AREA_RST;
      area2_r   <= `ISLP_AREA_RST;
      area3_r   <= `ISLP_AREA_RST;
      reason_r  <= `ISLP_REASON_RST;
      memAddr_r <= {(AW+2){1'b0}};
    end else if (ce && regWr) begin
      case (regAddr)
        `ISLP_REG_CFG:    cfg_r     <= regWrData[1:0];
        `ISLP_REG_OUI:    oui_r     <= regWrData[23:0];
        `ISLP_REG_AREA12: begin
          area1_r <= regWrData[15:0];
          area2_r <= regWrData[31:16];
        end
        `ISLP_REG_AREA3:  area3_r   <= regWrData[15:0];
        `ISLP_REG_REASON: reason_r  <= regWrData;
        `ISLP_REG_MEMADDR: memAddr_r <= regWrData[AW+1:0];
        `ISLP_REG_MEMDATA: memAddr_r <= memAddr_r + 1'b1;
        default: memAddr_r <= memAddr_r;
      endcase
    end
  end
  // Register read data, one cycle after the strobe
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData_r <= 32'h0000_0000;
    end else if (ce) begin
      regRdData_r <= 32'h0000_0000;
      if (regRd) begin
        case (regAddr)
          `ISLP_REG_CFG:    regRdData_r <= {30'h0000_0000, cfg_r};
          `ISLP_REG_OUI:    regRdData_r <= {8'h00, oui_r};
          `ISLP_REG_AREA12: regRdData_r <= {area2_r, area1_r};
          `ISLP_REG_AREA3:  regRdData_r <= {16'h0000, area3_r};
          `ISLP_REG_REASON: regRdData_r <= reason_r;
          `ISLP_REG_STATUS: regRdData_r <= {14'h0000, liveBank_r,
                                            snapValid_r, savedGen_r,
                                            7'h00, savedAvail_r};
          `ISLP_REG_MEMADDR: regRdData_r <= {{(30-AW){1'b0}}, memAddr_r};
          default:          regRdData_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Snapshot of the current log
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      snapValid_r  <= 1'b0;
      liveBank_r   <= 1'b0;
      frozenBank_r <= 1'b0;
      snapOui_r    <= `ISLP_OUI_RST;
      snapA1_r     <= `ISLP_AREA_RST;
      snapA2_r     <= `ISLP_AREA_RST;
      snapA3_r     <= `ISLP_AREA_RST;
      snapRsn_r    <= `ISLP_REASON_RST;
    end else if (ce) begin
      if (accept && !cmdBad && takeSnap) begin
        snapValid_r  <= 1'b1;
        frozenBank_r <= liveBank_r;
        liveBank_r   <= ~liveBank_r;
        snapOui_r    <= oui_r;
        snapA1_r     <= a1Eff;
        snapA2_r     <= a2Eff;
        snapA3_r     <= a3Eff;
        snapRsn_r    <= reason_r;
      end else if (ucodeAct) begin
        snapValid_r  <= 1'b0;
      end
    end
  end
  always @(posedge ref_clk or posedge nvClr) begin
    if (nvClr) begin
      savedAvail_r <= 1'b0;
      savedGen_r   <= 8'h00;
      savedOui_r   <= `ISLP_OUI_RST;
      savedA1_r    <= `ISLP_AREA_RST;
      savedA2_r    <= `ISLP_AREA_RST;
      savedA3_r    <= `ISLP_AREA_RST;
      savedRsn_r   <= `ISLP_REASON_RST;
    end else if (ce) begin
      if (capStart && savedSup) begin
        savedGen_r <= savedGen_r + 8'h01;
      end
      // set on stored capture, wins over clear
      if (capCommit && savedSup) begin
        savedAvail_r <= 1'b1;
        savedOui_r   <= oui_r;
        savedA1_r    <= a1Eff;
        savedA2_r    <= a2Eff;
        savedA3_r    <= a3Eff;
        savedRsn_r   <= reason_r;
      end else if (accept && !cmdBad && isSav &&
                   (cmdPage != 16'h0000)) begin
        savedAvail_r <= 1'b0;
      end
    end
  end
  // Command acceptance and byte sequencing
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      busy_r     <= 1'b0;
      cmdErr_r   <= 1'b0;
      idx_r      <= 9'h000;
      src_r      <= SRC_HDR;
      log_r      <= 8'h00;
      rgn_r      <= 2'h0;
      pg_r       <= {PGW{1'b0}};
      hdrAvail_r <= 1'b0;
      p1Valid_r  <= 1'b0;
      p1Idx_r    <= 9'h000;
      p1Last_r   <= 1'b0;
    end else if (ce) begin
      cmdErr_r  <= accept & cmdBad;
      p1Valid_r <= busy_r;
      p1Idx_r   <= idx_r;
      p1Last_r  <= busy_r & (idx_r == `ISLP_PAGE_LAST);
      if (accept && !cmdBad) begin
        busy_r     <= 1'b1;
        idx_r      <= 9'h000;
        log_r      <= cmdLog;
        hdrAvail_r <= savedAvail_r;
        pg_r       <= pgIdx[PGW-1:0];
        if (isSec) begin
          src_r <= SRC_SEC;
          rgn_r <= 2'h3;
        end else if (cmdPage == 16'h0000) begin
          src_r <= SRC_HDR;
          rgn_r <= 2'h0;
        end else begin
          src_r <= SRC_MEM;
          rgn_r <= isCur ? {1'b0, (takeSnap ? liveBank_r : frozenBank_r)}
                         : 2'h2;
        end
      end else if (busy_r) begin
        idx_r <= idx_r + 9'h001;
        if (idx_r == `ISLP_PAGE_LAST) begin
          busy_r <= 1'b0;
        end
      end
    end
  end
  // Output byte stage
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dataValid_r <= 1'b0;
      dataByte_r  <= 8'h00;
      dataLast_r  <= 1'b0;
    end else if (ce) begin
      dataValid_r <= p1Valid_r;
      dataLast_r  <= p1Last_r;
      dataByte_r  <= p1Valid_r ? outByte : 8'h00;
    end
  end
  // Vendor pages, saved pages and descriptor table
  islp_page_ram #(
    .AW (AW)
  ) u_ram (
    .ref_clk  (ref_clk),
    .ce       (ce),
    .wrEn     (memWr),
    .wrAddr   (memWrAddr),
    .wrData   (regWrData[7:0]),
    .rdAddr   (memRdAddr),
    .rdData_r (memRd)
  );
endmodule // islp_log_pages

// ---- hdl/islp_map.vh ----
`ifndef ISLP_MAP_VH
`define ISLP_MAP_VH

// Log identifiers
`define ISLP_LOG_CURRENT   8'h24
`define ISLP_LOG_SAVED     8'h25
`define ISLP_LOG_SECTOR    8'h2F

// Register byte addresses
`define ISLP_REG_CFG       8'h00
`define ISLP_REG_CMD       8'h04
`define ISLP_REG_OUI       8'h08
`define ISLP_REG_AREA12    8'h0C
`define ISLP_REG_AREA3     8'h10
`define ISLP_REG_REASON    8'h14
`define ISLP_REG_STATUS    8'h18
`define ISLP_REG_MEMADDR   8'h1C
`define ISLP_REG_MEMDATA   8'h20

// Configuration and command bit positions
`define ISLP_CFG_AREA1DATA 0
`define ISLP_CFG_SAVEDSUP  1
`define ISLP_CMD_CAPSTART  0
`define ISLP_CMD_CAPCOMMIT 1

// Reset values
`define ISLP_CFG_RST       2'h0
`define ISLP_OUI_RST       24'h00_0000
`define ISLP_AREA_RST      16'h0000
`define ISLP_REASON_RST    32'h0000_0000

// Memory regions as seen by firmware
`define ISLP_RGN_LIVE      2'h0
`define ISLP_RGN_SAVED     2'h1
`define ISLP_RGN_SECTOR    2'h2

// Header page byte positions
`define ISLP_HDR_ID        9'h000
`define ISLP_HDR_OUI0      9'h004
`define ISLP_HDR_OUI1      9'h005
`define ISLP_HDR_OUI2      9'h006
`define ISLP_HDR_A1LO      9'h008
`define ISLP_HDR_A1HI      9'h009
`define ISLP_HDR_A2LO      9'h00A
`define ISLP_HDR_A2HI      9'h00B
`define ISLP_HDR_A3LO      9'h00C
`define ISLP_HDR_A3HI      9'h00D
`define ISLP_HDR_AVAIL     9'h17E
`define ISLP_HDR_GEN       9'h17F
`define ISLP_HDR_RSN0      9'h180
`define ISLP_HDR_RSN1      9'h181
`define ISLP_HDR_RSN2      9'h182
`define ISLP_HDR_RSN3      9'h183
`define ISLP_PAGE_LAST     9'h1FF

// Sector configuration layout
`define ISLP_SEC_TABLE_END 9'h080
`define ISLP_SEC_RSVD_OFS  4'h8
`define ISLP_SEC_VALID_MSK 8'h80

`endif

// ---- hdl/islp_page_ram.v ----
// Byte memory with registered read data
module islp_page_ram #(
  parameter AW = 14
) (
  input  wire          ref_clk,
  input  wire          ce,
  input  wire          wrEn,
  input  wire [AW-1:0] wrAddr,
  input  wire [7:0]    wrData,
  input  wire [AW-1:0] rdAddr,
  output reg  [7:0]    rdData_r
);

  reg [7:0] mem [0:(1<<AW)-1];

  // Write port and registered read port
  always @(posedge ref_clk) begin
    if (ce) begin
      if (wrEn) begin
        mem[wrAddr] <= wrData;
      end
      rdData_r <= mem[rdAddr];
    end
  end

endmodule // islp_page_ram

// ---- test/islp_chk.sv ----
module islp_chk #(
  parameter PGW = 3
) (
  input logic        ref_clk,
  input logic        rst,
  input logic        ce,
  input logic        regRd,
  input logic [31:0] regRdData_r,
  input logic        cmdValid,
  input logic [7:0]  cmdLog,
  input logic [15:0] cmdPage,
  input logic        busy_r,
  input logic        cmdErr_r,
  input logic        dataValid_r,
  input logic [7:0]  dataByte_r,
  input logic        dataLast_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] idx;
  logic [9:0] bCnt;
  logic [7:0] pLog;
  logic       pZero;
  wire take = ce && cmdValid && !busy_r;
  wire hdrB = dataValid_r && pZero && pLog != 8'h2F;
  wire secB = dataValid_r && pLog == 8'h2F;
  // Byte position, busy length and accepted command
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idx <= 9'h000;
      bCnt <= 10'h000;
      pLog <= 8'h00;
      pZero <= 1'b0;
    end else begin
      idx <= dataValid_r ? idx + 9'h001 : idx;
      bCnt <= busy_r ? bCnt + 10'h001 : 10'h000;
      pLog <= take ? cmdLog : pLog;
      pZero <= take ? cmdPage == 16'h0000 : pZero;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_take_one: assert property (take |=> busy_r != cmdErr_r)
    else $error("command neither streamed nor refused");
  chk_bad_log: assert property (take && !(cmdLog inside {8'h24, 8'h25,
    8'h2F}) |=> cmdErr_r && !busy_r) else $error("unknown log accepted");
  chk_sec_page: assert property (
    take && cmdLog == 8'h2F && cmdPage != 16'h0000 |=> cmdErr_r)
    else $error("sector page above zero accepted");
  chk_first_byte: assert property (
    $rose(busy_r) |-> ##2 dataValid_r && idx == 9'h000)
    else $error("first byte late or early");
  chk_busy_len: assert property (
    $fell(busy_r) |-> bCnt == 10'h200) else $error("busy not 512 cycles");
  chk_last_byte: assert property (
    dataValid_r |-> dataLast_r == (idx == 9'h1FF))
    else $error("last marker misplaced");
  chk_idle_zero: assert property (
    !dataValid_r |-> dataByte_r == 8'h00 && !dataLast_r)
    else $error("byte output not idle");
  chk_log_id: assert property (
    hdrB && idx == 9'h000 |-> dataByte_r == pLog)
    else $error("header byte zero wrong");
  chk_hdr_rsvd: assert property (
    hdrB && idx inside {[1:3], 7, [14:381]} |-> dataByte_r == 8'h00)
    else $error("reserved header byte set");
  chk_sec_rsvd: assert property (
    secB && (idx >= 9'h080 || idx[3]) |-> dataByte_r == 8'h00)
    else $error("reserved sector byte set");
  chk_sec_flag: assert property (
    secB && idx[3:0] == 4'h0 |-> dataByte_r[6:0] == 7'h00)
    else $error("descriptor flag reserved bits set");
  chk_reg_idle: assert property (!$past(regRd) |-> regRdData_r == 0)
    else $error("read data outside answer cycle");
  cover property ($rose(busy_r) && pLog == 8'h25);
  cover property (secB && dataLast_r);
  cover property (cmdErr_r);
endmodule // islp_chk

bind islp_log_pages islp_chk #(.PGW(PGW)) u_chk (.*);

// ---- test/islp_host_model.sv ----
module islp_host_model (
  input  logic        ref_clk,
  input  logic        busy_r,
  input  logic        cmdErr_r,
  input  logic        dataValid_r,
  input  logic [7:0]  dataByte_r,
  input  logic        dataLast_r,
  output logic        cmdValid,
  output logic [7:0]  cmdLog,
  output logic [15:0] cmdPage,
  output logic        cmdFeat0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] got [512];
  int         n = 0;
  // Idle request lines
  initial begin
    cmdValid = 1'b0;
    cmdLog = 8'h00;
    cmdPage = 16'h0000;
    cmdFeat0 = 1'b0;
  end
  // Store streamed bytes in order
  always @(posedge ref_clk) begin
    if (dataValid_r) begin
      got[n] <= dataByte_r;
      n <= dataLast_r ? 0 : n + 1;
    end
  end
  // One log read, waiting out a running page first
  task automatic read_log(input logic [7:0] lg, input logic [15:0] pg,
                          input logic ft, output logic err);
    int t;
    @(posedge ref_clk);
    while (busy_r) @(posedge ref_clk);
    cmdValid <= 1'b1;
    cmdLog <= lg;
    cmdPage <= pg;
    cmdFeat0 <= ft;
    @(posedge ref_clk);
    cmdValid <= 1'b0;
    cmdLog <= ~lg;
    cmdPage <= ~pg;
    cmdFeat0 <= ~ft;
    #1 err = cmdErr_r;
    t = 0;
    while (!err && !(dataValid_r && dataLast_r) && t < 600) begin
      @(posedge ref_clk);
      #1 t++;
    end
    @(posedge ref_clk);
    #1;
  endtask
endmodule // islp_host_model

// ---- test/test_internal_status_log_pages.sv ----
module test_internal_status_log_pages;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        nvClr = 1'b1;
  logic        ce = 1'b1;
  logic [7:0]  regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0000_0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic        ucodeAct = 1'b0;
  logic [31:0] regRdData_r;
  logic        cmdValid, cmdFeat0, busy_r, cmdErr_r;
  logic        dataValid_r, dataLast_r, err;
  logic [7:0]  cmdLog, dataByte_r;
  logic [15:0] cmdPage;
  logic [31:0] lfsr = 32'h9e84_dccc;
  logic [31:0] s, rsn;
  logic [23:0] oui;
  logic [15:0] a1, a2, a3;
  logic [7:0]  expPg [512];
  logic [7:0]  keep [512];
  logic [7:0]  errLog [4] = '{8'h25, 8'h24, 8'h30, 8'h2F};
  logic [15:0] errPg [4] = '{16'h0000, 16'h0001, 16'h0000, 16'h0001};
  int          nMismatch = 0;
  int          cmpCount = 0;
  always #2 ref_clk = ~ref_clk;
  islp_log_pages #(.PGW(3)) dut (.*);
  islp_host_model host (.*);
  function automatic logic [7:0] rnd8();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic chk(input string nm, input logic [31:0] sv, ev);
    cmpCount++;
    if (sv !== ev) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", nm, ev, sv);
    end
  endtask
  task automatic stop_test();
    if (nMismatch == 0 && cmpCount > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 s = regRdData_r;
  endtask
  task automatic stat(input logic av, input logic [7:0] gn);
    rd(8'h18);
    chk("status", s[15:0], {gn, 7'h00, av});
  endtask
  // Configure header fields and work out the reported bounds
  task automatic setup(input logic [1:0] cf, input logic [15:0] r1, r2, r3);
    oui = {rnd8(), rnd8(), rnd8()};
    rsn = {rnd8(), rnd8(), rnd8(), rnd8()};
    wr(8'h00, {30'h0000_0000, cf});
    wr(8'h08, {rnd8(), oui});
    wr(8'h0C, {r2, r1});
    wr(8'h10, {16'h0000, r3});
    wr(8'h14, rsn);
    a1 = cf[0] ? r1 : 16'h0000;
    a2 = r2 > a1 ? r2 : a1;
    a3 = r3 > a2 ? r3 : a2;
  endtask
  // Random page into a memory region
  task automatic fill(input logic [1:0] rg);
    // The descriptor table sits in the top page slot of its region
    wr(8'h1C, {16'h0000, rg, rg == 2'h2 ? 14'h0E00 : 14'h0000});
    foreach (expPg[i]) begin
      expPg[i] = rnd8();
      wr(8'h20, {24'h00_0000, expPg[i]});
    end
  endtask
  task automatic hdr(input logic [7:0] id, av, gn);
    foreach (expPg[i]) expPg[i] = 8'h00;
    expPg[0] = id;
    {expPg[6], expPg[5], expPg[4]} = oui;
    {expPg[9], expPg[8]} = a1;
    {expPg[11], expPg[10]} = a2;
    {expPg[13], expPg[12]} = a3;
    expPg[382] = av;
    expPg[383] = gn;
    {expPg[387], expPg[386], expPg[385], expPg[384]} = rsn;
  endtask
  task automatic page(input logic [7:0] lg, input logic [15:0] pg,
                      input logic ft);
    host.read_log(lg, pg, ft, err);
    chk("refused", err, 0);
    foreach (expPg[i]) chk("byte", host.got[i], expPg[i]);
  endtask
  task automatic lerr(input logic [7:0] lg, input logic [15:0] pg, e);
    host.read_log(lg, pg, 1'b0, err);
    chk("refused", err, e);
  endtask
  // Watchdog
  initial begin
    #200us;
    nMismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    nvClr <= 1'b0;
    setup(2'h3, 16'h0003, 16'h0002, 16'h0005);
    rd(8'h08);
    chk("oui", s, {8'h00, oui});
    // A write taken while ce is low must be lost
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(8'h08, {8'h00, ~oui});
    ce <= 1'b1;
    rd(8'h08);
    chk("frozen", s, {8'h00, oui});
    rd(8'h40);
    chk("unmapped", s, 0);
    stat(1'b0, 8'h00);
    wr(8'h04, 32'h0000_0001);
    stat(1'b0, 8'h01);
    wr(8'h04, 32'h0000_0002);
    stat(1'b1, 8'h01);
    fill(2'h0);
    keep = expPg;
    hdr(8'h24, 8'h01, 8'h01);
    page(8'h24, 16'h0000, 1'b1);
    fill(2'h0);
    expPg = keep;
    page(8'h24, 16'h0001, 1'b0);
    hdr(8'h25, 8'h01, 8'h01);
    page(8'h25, 16'h0000, 1'b0);
    stat(1'b1, 8'h01);
    fill(2'h1);
    page(8'h25, 16'h0001, 1'b0);
    stat(1'b0, 8'h01);
    hdr(8'h24, 8'h00, 8'h01);
    page(8'h24, 16'h0000, 1'b1);
    lerr(8'h24, 16'h0005, 1'b0);
    lerr(8'h24, 16'h0006, 1'b1);
    rd(8'h18);
    chk("snapshot", s[16], 1);
    @(posedge ref_clk);
    ucodeAct <= 1'b1;
    @(posedge ref_clk);
    ucodeAct <= 1'b0;
    rd(8'h18);
    chk("snapshot", s[16], 0);
    wr(8'h04, 32'h0000_0001);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    stat(1'b0, 8'h02);
    for (int k = 0; k < 4; k++) lerr(errLog[k], errPg[k], 1'b1);
    setup(2'h2, 16'h0003, 16'h0002, 16'h0001);
    hdr(8'h24, 8'h00, 8'h02);
    page(8'h24, 16'h0000, 1'b1);
    fill(2'h2);
    foreach (expPg[i]) begin
      if (i >= 128 || i % 16 >= 8) expPg[i] = 8'h00;
      else if (i % 16 == 0) expPg[i] = expPg[i] & 8'h80;
    end
    page(8'h2F, 16'h0000, 1'b0);
    stop_test();
  end
endmodule // test_internal_status_log_pages
